// [pwmcc_pkg.sv]
// constants for the motor pwm carrier counter and buffer update block
// Contract
// - timing 00, cycle nonzero: load at peak only
// - timing 01 loads at bottom, 10 at peak
// - timing 11 loads at peak and bottom
// - 00 half cycle both; sawtooth peak only
// - vector values need mode, enable, triangle carrier
// - select 0 split: bus up, vector down
// - timing 01/10 or select 1: vector value
// - direction bit reads 0 up, 1 down
// - sawtooth carrier: direction bit reads zero
// - live 16-bit counter readable in bits 15-0
// - normal mode advances every system clock
// - extension mode advances every four clocks
// - disabled: hold 0x0001 sawtooth, period triangle
// - triangle doubles step: two or eight clocks
`default_nettype none

package pwmcc_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PERIOD = 8'h04;
    localparam logic [7:0] OFF_CMP_U = 8'h08;
    localparam logic [7:0] OFF_CMP_V = 8'h0c;
    localparam logic [7:0] OFF_CMP_W = 8'h10;
    localparam logic [7:0] OFF_DIR_STAT = 8'h14;
    localparam logic [7:0] OFF_CNT_VAL = 8'h18;
    localparam logic [7:0] OFF_PRD_WORK = 8'h1c;

    // control register fields
    localparam int CTL_EN = 0;
    localparam int CTL_TRI = 1;
    localparam int CTL_EXT = 2;
    localparam int CTL_INTPRD = 3;
    localparam int CTL_DSYNC = 5;
    localparam int CTL_SRCMODE = 7;
    localparam int CTL_VCMPEN = 8;
    localparam int CTL_PHSEL = 9;
    localparam int CTL_WIDTH = 12;

    // reset values
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [15:0] PERIOD_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'h0000;

    // counting steps in system clocks
    localparam logic [3:0] STEP_SAW_NORM = 4'h1;
    localparam logic [3:0] STEP_TRI_NORM = 4'h2;
    localparam logic [3:0] STEP_SAW_EXT = 4'h4;
    localparam logic [3:0] STEP_TRI_EXT = 4'h8;

    localparam logic [15:0] PRD_MIN = 16'h0010;
    localparam logic [15:0] CNT_BOTTOM = 16'h0001;
    localparam logic [1:0] INTPRD_HALF = 2'h0;

    typedef enum logic [1:0] {
        UPD_AUTO = 2'b00,
        UPD_BOTTOM = 2'b01,
        UPD_PEAK = 2'b10,
        UPD_BOTH = 2'b11
    } pwmcc_upd_type;

endpackage : pwmcc_pkg

`default_nettype wire

// [pwmcc_upd_sel.sv]
// buffer update timing and compare source selection decode
`default_nettype none

module pwmcc_upd_sel (
    // common settings
    input wire logic [1:0] dsyncs,
    input wire logic [1:0] intprd,
    input wire logic tri_mode,
    input wire logic src_mode,
    input wire logic vcmp_en,
    input wire logic [2:0] phase_sel,
    // carrier state
    input wire logic peak,
    input wire logic bottom,
    input wire logic count_down,
    // decisions
    output logic load,
    output logic [2:0] use_ve
);

    logic at_peak;
    logic at_bot;
    logic half;
    logic split;
    logic all_ve;
    logic active;

    always_comb
    begin
        half = (intprd == pwmcc_pkg::INTPRD_HALF);
        case (pwmcc_pkg::pwmcc_upd_type'(dsyncs))
            pwmcc_pkg::UPD_AUTO:
            begin
                at_peak = 1'b1;
                at_bot = half;
            end
            pwmcc_pkg::UPD_BOTTOM:
            begin
                at_peak = 1'b0;
                at_bot = 1'b1;
            end
            pwmcc_pkg::UPD_PEAK:
            begin
                at_peak = 1'b1;
                at_bot = 1'b0;
            end
            pwmcc_pkg::UPD_BOTH:
            begin
                at_peak = 1'b1;
                at_bot = 1'b1;
            end
            default:
            begin
                at_peak = 1'b1;
                at_bot = 1'b0;
            end
        endcase
        // a sawtooth has no real bottom turn: peak only
        if (!tri_mode)
        begin
            at_peak = 1'b1;
            at_bot = 1'b0;
        end
        load = (peak & at_peak) | (bottom & at_bot);
        active = src_mode & vcmp_en & tri_mode;
        split = (dsyncs == pwmcc_pkg::UPD_BOTH)
            | ((dsyncs == pwmcc_pkg::UPD_AUTO) & half);
        all_ve = (dsyncs == pwmcc_pkg::UPD_BOTTOM)
            | (dsyncs == pwmcc_pkg::UPD_PEAK);
        for (int i = 0; i < 3; i++)
        begin
            use_ve[i] = active
                & (all_ve | phase_sel[i] | (split & count_down));
        end
    end

endmodule : pwmcc_upd_sel

`default_nettype wire

// [pwmcc_apb.sv]
// apb slave handshake: no wait states, registered read data
`default_nettype none

module pwmcc_apb (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    // register file side
    input wire logic [31:0] rd_word,
    input wire logic rd_hit,
    output logic wr_stb,
    // apb answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pwmcc_apb_state_type;

    pwmcc_apb_state_type st_r;
    pwmcc_apb_state_type st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        // read data is captured in the setup cycle, so the value seen
        // is the one present at that edge
        if (psel && !penable && !st_r.pready)
        begin
            st_nxt.pready = 1'b1;
            st_nxt.pslverr = !rd_hit;
            st_nxt.prdata = (rd_hit && !pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign wr_stb = psel & penable & pwrite & st_r.pready & !st_r.pslverr;
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;

endmodule : pwmcc_apb

`default_nettype wire

// [pwmcc_top.sv]
// pwm carrier counter with double-buffered period and compare stages
//
// The register offsets and the APB slave port were left to the implementer.
`default_nettype none

module pwmcc_top (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // vector engine compare values
    input wire logic [15:0] ve_cmp_u,
    input wire logic [15:0] ve_cmp_v,
    input wire logic [15:0] ve_cmp_w,
    // carrier state
    output logic [15:0] carrier_cnt,
    output logic carrier_down,
    output logic peak_pulse,
    output logic bottom_pulse,
    output logic load_pulse,
    // working compare values for the pulse comparators
    output logic [15:0] cmp_u_out,
    output logic [15:0] cmp_v_out,
    output logic [15:0] cmp_w_out
);

    typedef struct packed {
        logic [11:0] ctrl;
        logic [15:0] prd_buf;
        logic [15:0] prd_work;
        logic [2:0][15:0] cmp_buf;
        logic [2:0][15:0] cmp_work;
        logic [2:0][15:0] ve_work;
        logic [2:0][15:0] cmp_out;
        logic [15:0] cnt;
        logic down;
        logic [2:0] pre;
        logic peak;
        logic bottom;
        logic load;
    } pwmcc_state_type;

    pwmcc_state_type st_r;
    pwmcc_state_type st_nxt;

    logic en;
    logic tri_mode;
    logic ext;
    logic [2:0] pre_last;
    logic tick;
    logic [15:0] prd_e;
    logic evt_peak;
    logic evt_bot;
    logic upd_load;
    logic [2:0] use_ve;
    logic wr_stb;
    logic [32:0] rd_res;
    logic [2:0][15:0] ve_in;

    // short periods run as the minimum; the register keeps what was written
    function automatic logic [15:0] eff_period(input logic [15:0] p);
        eff_period = (p < pwmcc_pkg::PRD_MIN) ? pwmcc_pkg::PRD_MIN : p;
    endfunction : eff_period

    function automatic logic [2:0] step_last(input logic [3:0] step);
        step_last = 3'(step - 4'h1);
    endfunction : step_last

    // returns {hit, data}
    function automatic logic [32:0] reg_read(
        input logic [7:0] a,
        input pwmcc_state_type s
    );
        logic tri_s;
        tri_s = s.ctrl[pwmcc_pkg::CTL_TRI];
        case (a)
            pwmcc_pkg::OFF_CTRL:
                reg_read = {1'b1, 20'h00000, s.ctrl};
            pwmcc_pkg::OFF_PERIOD:
                reg_read = {1'b1, 16'h0000, s.prd_buf};
            pwmcc_pkg::OFF_CMP_U:
                reg_read = {1'b1, 16'h0000, s.cmp_buf[0]};
            pwmcc_pkg::OFF_CMP_V:
                reg_read = {1'b1, 16'h0000, s.cmp_buf[1]};
            pwmcc_pkg::OFF_CMP_W:
                reg_read = {1'b1, 16'h0000, s.cmp_buf[2]};
            pwmcc_pkg::OFF_DIR_STAT:
                reg_read = {1'b1, 31'h0000_0000, s.down & tri_s};
            pwmcc_pkg::OFF_CNT_VAL:
                reg_read = {1'b1, 16'h0000, s.cnt};
            pwmcc_pkg::OFF_PRD_WORK:
                reg_read = {1'b1, 16'h0000, s.prd_work};
            default:
                reg_read = {1'b0, 32'h0000_0000};
        endcase
    endfunction : reg_read

    assign en = st_r.ctrl[pwmcc_pkg::CTL_EN];
    assign tri_mode = st_r.ctrl[pwmcc_pkg::CTL_TRI];
    assign ext = st_r.ctrl[pwmcc_pkg::CTL_EXT];
    assign ve_in[0] = ve_cmp_u;
    assign ve_in[1] = ve_cmp_v;
    assign ve_in[2] = ve_cmp_w;

    // step length in clocks
    always_comb
    begin
        case ({tri_mode, ext})
            2'b00: pre_last = step_last(pwmcc_pkg::STEP_SAW_NORM);
            2'b01: pre_last = step_last(pwmcc_pkg::STEP_SAW_EXT);
            2'b10: pre_last = step_last(pwmcc_pkg::STEP_TRI_NORM);
            2'b11: pre_last = step_last(pwmcc_pkg::STEP_TRI_EXT);
            default: pre_last = 3'h0;
        endcase
    end

    assign tick = en & (st_r.pre >= pre_last);
    assign prd_e = eff_period(st_r.prd_work);
    assign evt_peak = tick & (st_r.cnt >= prd_e) & (!tri_mode | !st_r.down);
    assign evt_bot = tick & tri_mode & st_r.down
        & (st_r.cnt <= pwmcc_pkg::CNT_BOTTOM);
    assign rd_res = reg_read(paddr, st_r);

    pwmcc_upd_sel u_upd_sel (
        .dsyncs(st_r.ctrl[pwmcc_pkg::CTL_DSYNC +: 2]),
        .intprd(st_r.ctrl[pwmcc_pkg::CTL_INTPRD +: 2]),
        .tri_mode(tri_mode),
        .src_mode(st_r.ctrl[pwmcc_pkg::CTL_SRCMODE]),
        .vcmp_en(st_r.ctrl[pwmcc_pkg::CTL_VCMPEN]),
        .phase_sel(st_r.ctrl[pwmcc_pkg::CTL_PHSEL +: 3]),
        .peak(evt_peak),
        .bottom(evt_bot),
        .count_down(st_r.down),
        .load(upd_load),
        .use_ve(use_ve)
    );

    pwmcc_apb u_apb (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .rd_word(rd_res[31:0]),
        .rd_hit(rd_res[32]),
        .wr_stb(wr_stb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.peak = evt_peak;
        st_nxt.bottom = evt_bot;
        st_nxt.load = en & upd_load;
        if (wr_stb)
        begin
            case (paddr)
                pwmcc_pkg::OFF_CTRL:
                    st_nxt.ctrl = pwdata[pwmcc_pkg::CTL_WIDTH-1:0];
                pwmcc_pkg::OFF_PERIOD:
                    st_nxt.prd_buf = pwdata[15:0];
                pwmcc_pkg::OFF_CMP_U:
                    st_nxt.cmp_buf[0] = pwdata[15:0];
                pwmcc_pkg::OFF_CMP_V:
                    st_nxt.cmp_buf[1] = pwdata[15:0];
                pwmcc_pkg::OFF_CMP_W:
                    st_nxt.cmp_buf[2] = pwdata[15:0];
                default:
                    st_nxt.ctrl = st_r.ctrl;
            endcase
        end
        if (!en)
        begin
            // idle: working stages follow the buffers so enabling starts
            // from the programmed values
            st_nxt.pre = 3'h0;
            st_nxt.down = 1'b0;
            st_nxt.cnt = tri_mode ? st_r.prd_buf : pwmcc_pkg::CNT_BOTTOM;
            st_nxt.prd_work = st_r.prd_buf;
            st_nxt.cmp_work = st_r.cmp_buf;
            st_nxt.ve_work = ve_in;
        end
        else
        begin
            st_nxt.pre = tick ? 3'h0 : 3'(st_r.pre + 3'h1);
            if (tick)
            begin
                if (!tri_mode)
                begin
                    // up only, wrap after the period
                    st_nxt.cnt = evt_peak ? pwmcc_pkg::CNT_BOTTOM
                        : 16'(st_r.cnt + 16'h0001);
                end
                else if (evt_peak)
                begin
                    st_nxt.down = 1'b1;
                    st_nxt.cnt = 16'(st_r.cnt - 16'h0001);
                end
                else if (evt_bot)
                begin
                    st_nxt.down = 1'b0;
                    st_nxt.cnt = 16'(st_r.cnt + 16'h0001);
                end
                else if (st_r.down)
                    st_nxt.cnt = 16'(st_r.cnt - 16'h0001);
                else
                    st_nxt.cnt = 16'(st_r.cnt + 16'h0001);
            end
            if (upd_load)
            begin
                st_nxt.prd_work = st_r.prd_buf;
                st_nxt.cmp_work = st_r.cmp_buf;
                st_nxt.ve_work = ve_in;
            end
        end
        if (!tri_mode)
            st_nxt.down = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            st_nxt.cmp_out[i] = use_ve[i] ? st_r.ve_work[i]
                : st_r.cmp_work[i];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.ctrl <= pwmcc_pkg::CTRL_RST;
            st_r.prd_buf <= pwmcc_pkg::PERIOD_RST;
            st_r.cmp_buf <= {3{pwmcc_pkg::CMP_RST}};
        end
        else
            st_r <= st_nxt;
    end

    assign carrier_cnt = st_r.cnt;
    assign carrier_down = st_r.down;
    assign peak_pulse = st_r.peak;
    assign bottom_pulse = st_r.bottom;
    assign load_pulse = st_r.load;
    assign cmp_u_out = st_r.cmp_out[0];
    assign cmp_v_out = st_r.cmp_out[1];
    assign cmp_w_out = st_r.cmp_out[2];

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    a_auto_peak_only: assert property (
        (en && tri_mode && st_r.ctrl[6:5] == 2'b00
            && st_r.ctrl[4:3] != 2'b00 && evt_bot) |=> !st_r.load)
        else $error("buffers loaded at bottom in auto timing");

    a_bottom_load: assert property (
        (en && tri_mode && st_r.ctrl[6:5] == 2'b01 && evt_bot)
            |=> st_r.load && st_r.prd_work == $past(st_r.prd_buf))
        else $error("bottom timing did not load buffers");

    a_both_load: assert property (
        (en && st_r.ctrl[6:5] == 2'b11 && (evt_peak || evt_bot))
            |=> st_r.load)
        else $error("peak or bottom load missed");

    a_saw_peak_load: assert property (
        (st_r.load && !$past(tri_mode)) |-> st_r.peak)
        else $error("sawtooth load away from peak");

    a_bus_source: assert property (
        !st_r.ctrl[pwmcc_pkg::CTL_SRCMODE]
            |=> cmp_u_out == $past(st_r.cmp_work[0]))
        else $error("bus compare value not used");

    a_split_up: assert property (
        (st_r.ctrl[8:7] == 2'b11 && tri_mode && st_r.ctrl[6:5] == 2'b11
            && !st_r.ctrl[9] && !st_r.down)
            |=> cmp_u_out == $past(st_r.cmp_work[0]))
        else $error("up-count phase did not use bus value");

    a_ve_source: assert property (
        (st_r.ctrl[8:7] == 2'b11 && tri_mode && st_r.ctrl[10])
            |=> cmp_v_out == $past(st_r.ve_work[1]))
        else $error("vector value not used for selected phase");

    a_peak_turn: assert property (
        (tri_mode && evt_peak) |=> carrier_down ##1 !peak_pulse)
        else $error("direction flag not set after peak");

    a_saw_dir: assert property (
        !tri_mode |=> !carrier_down)
        else $error("direction set on sawtooth carrier");

    a_cnt_read: assert property (
        (psel && !penable && !pready && !pwrite
            && paddr == pwmcc_pkg::OFF_CNT_VAL)
            |=> prdata == {16'h0000, $past(st_r.cnt)})
        else $error("counter read value wrong");

    a_norm_step: assert property (
        (en && !tri_mode && !ext && st_r.pre == 3'h0
            && st_r.cnt < prd_e)
            |=> carrier_cnt == 16'($past(st_r.cnt) + 16'h0001))
        else $error("sawtooth counter missed a clock");

    a_ext_step: assert property (
        (en && !tri_mode && ext && $changed(st_r.cnt)
            && $stable(st_r.ctrl))
            |=> (!$past(en) || !$past(ext) || $past(tri_mode)
                || $stable(st_r.cnt))[*3])
        else $error("extended step shorter than four clocks");

    a_idle_hold: assert property (
        (!en && !tri_mode) |=> carrier_cnt == pwmcc_pkg::CNT_BOTTOM)
        else $error("idle sawtooth counter not at bottom");

endmodule : pwmcc_top

`default_nettype wire

// [pwm_carrier_counter_buffer_update_tb_top.sv]
// self-checking testbench for the pwm carrier counter block
`default_nettype none

module pwm_carrier_counter_buffer_update_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [15:0] ve_u = 16'h0a00;
    logic [15:0] ve_v = 16'h0b00;
    logic [15:0] ve_w = 16'h0c00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] cnt;
    logic down;
    logic peak_p;
    logic bot_p;
    logic load_p;
    logic [15:0] cu;
    logic [15:0] cv;
    logic [15:0] cw;
    int fail_count = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic err;
    localparam logic [47:0] BUS = 48'h0300_0200_0100;
    localparam logic [47:0] VEC = 48'h0c00_0b00_0a00;

    always #10 mclk = ~mclk;

    pwmcc_top uut (
        .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ve_cmp_u(ve_u),
        .ve_cmp_v(ve_v), .ve_cmp_w(ve_w), .carrier_cnt(cnt),
        .carrier_down(down), .peak_pulse(peak_p), .bottom_pulse(bot_p),
        .load_pulse(load_p), .cmp_u_out(cu), .cmp_v_out(cv),
        .cmp_w_out(cw)
    );

    task automatic check_val(input logic [47:0] got, input logic [47:0] exp,
                             input string msg);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s got %h expected %h",
                     $time, msg, got, exp);
        end
    endtask : check_val

    task automatic test_done;
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    // signals move only just after an edge; request held until ready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        check_val({47'h0, pready}, 48'h1, "bus answer");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string msg);
        apb(1'b0, a, 32'h0);
        check_val({15'h0, err, rd}, {16'h0, e}, msg);
    endtask : rdchk

    // kind 0 waits for a peak pulse, kind 1 for a bottom pulse
    task automatic wait_ev(input int kind);
        int n;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (((kind == 0) ? peak_p : bot_p) !== 1'b1 && n < 2000);
        check_val(48'(n < 2000), 48'h1, "carrier event");
    endtask : wait_ev

    task automatic test_reset;
        rdchk(pwmcc_pkg::OFF_DIR_STAT, 32'h0, "status");
        rdchk(pwmcc_pkg::OFF_CNT_VAL, 32'h1, "idle count");
        apb(1'b0, 8'h20, 32'h0);
        check_val({15'h0, err, rd}, {16'h1, 32'h0}, "unmapped");
        wr(pwmcc_pkg::OFF_CNT_VAL, 32'h0000_abcd);
        rdchk(pwmcc_pkg::OFF_CNT_VAL, 32'h1, "count ro");
    endtask : test_reset

    task automatic run_cnt(input logic [11:0] ctl, input logic [15:0] prd,
                           input int step, input logic [15:0] mx_e);
        int n;
        logic [15:0] mx;
        logic [15:0] mn;
        logic dn;
        wr(pwmcc_pkg::OFF_PERIOD, {16'h0, prd});
        rdchk(pwmcc_pkg::OFF_PERIOD, {16'h0, prd}, "period");
        rdchk(pwmcc_pkg::OFF_PRD_WORK, {16'h0, prd}, "work period");
        wr(pwmcc_pkg::OFF_CTRL, {20'h0, ctl});
        n = 0;
        while (cnt === 16'h0005 && n < 100)
        begin
            @(posedge mclk);
            n++;
        end
        n = 0;
        while (cnt !== 16'h0005 && n < 2000)
        begin
            @(posedge mclk);
            n++;
        end
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (cnt === 16'h0005 && n < 20);
        check_val(48'(n), 48'(step), "step");
        mx = 16'h0000;
        mn = 16'hffff;
        dn = 1'b0;
        repeat (600)
        begin
            @(posedge mclk);
            mx = (cnt > mx) ? cnt : mx;
            mn = (cnt < mn) ? cnt : mn;
            dn = dn | down;
        end
        check_val(48'({mx, mn}), 48'({mx_e, 16'h0001}), "range");
        check_val({47'h0, dn}, {47'h0, ctl[1]}, "dir");
        apb(1'b0, pwmcc_pkg::OFF_CNT_VAL, 32'h0);
        check_val(48'(rd[31:16]), 48'h0, "cnt high");
        check_val(48'(rd[15:0] >= 1 && rd[15:0] <= mx_e), 48'h1,
                  "cnt read");
        if (ctl[1])
        begin
            wait_ev(0);
            repeat (6) @(posedge mclk);
            rdchk(pwmcc_pkg::OFF_DIR_STAT, 32'h1, "down");
            wait_ev(1);
            repeat (6) @(posedge mclk);
            rdchk(pwmcc_pkg::OFF_DIR_STAT, 32'h0, "up");
        end
        wr(pwmcc_pkg::OFF_CTRL, {20'h0, ctl & 12'hffe});
        repeat (4) @(posedge mclk);
        check_val(48'({down, cnt}), ctl[1] ? {32'h0, prd} : 48'h1,
                  "idle");
    endtask : run_cnt

    task automatic check_load(input logic [11:0] ctl, input logic p_e,
                              input logic b_e);
        int np;
        int nb;
        int nx;
        np = 0;
        nb = 0;
        nx = 0;
        wr(pwmcc_pkg::OFF_CTRL, {20'h0, ctl});
        repeat (100) @(posedge mclk);
        repeat (300)
        begin
            @(posedge mclk);
            if (load_p === 1'b1)
            begin
                if (peak_p === 1'b1)
                    np++;
                else if (bot_p === 1'b1)
                    nb++;
                else
                    nx++;
            end
        end
        check_val({46'h0, np > 0, nb > 0}, {46'h0, p_e, b_e}, "load");
        check_val(48'(nx), 48'h0, "stray load");
    endtask : check_load

    task automatic check_src(input logic [11:0] ctl, input logic [47:0] up_e,
                             input logic [47:0] dn_e);
        wr(pwmcc_pkg::OFF_CTRL, {20'h0, ctl});
        wait_ev(0);
        wait_ev(1);
        wait_ev(0);
        repeat (6) @(posedge mclk);
        check_val({cw, cv, cu}, dn_e, "down compare");
        wait_ev(1);
        repeat (6) @(posedge mclk);
        check_val({cw, cv, cu}, up_e, "up compare");
    endtask : check_src

    initial
    begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        test_reset;
        run_cnt(12'h001, 16'h0020, 1, 16'h0020);
        run_cnt(12'h001, 16'h0004, 1, 16'h0010);
        run_cnt(12'h005, 16'h0010, 4, 16'h0010);
        run_cnt(12'h003, 16'h0018, 2, 16'h0018);
        run_cnt(12'h007, 16'h0010, 8, 16'h0010);
        wr(pwmcc_pkg::OFF_PERIOD, 32'h0000_0010);
        check_load(12'h00b, 1'b1, 1'b0);
        check_load(12'h013, 1'b1, 1'b0);
        check_load(12'h003, 1'b1, 1'b1);
        check_load(12'h023, 1'b0, 1'b1);
        check_load(12'h043, 1'b1, 1'b0);
        check_load(12'h063, 1'b1, 1'b1);
        check_load(12'h021, 1'b1, 1'b0);
        check_load(12'h000, 1'b0, 1'b0);
        wr(pwmcc_pkg::OFF_CMP_U, 32'h0000_0100);
        wr(pwmcc_pkg::OFF_CMP_V, 32'h0000_0200);
        wr(pwmcc_pkg::OFF_CMP_W, 32'h0000_0300);
        check_src(12'h1a3, VEC, VEC);
        check_src(12'h1c3, VEC, VEC);
        check_src(12'h1e3, BUS, VEC);
        check_src(12'h183, BUS, VEC);
        check_src(12'h5e3, 48'h0300_0b00_0100, VEC);
        check_src(12'h163, BUS, BUS);
        check_src(12'h18b, BUS, BUS);
        test_done;
    end

    // whole run is well under this many nanoseconds
    initial
    begin
        #1000000;
        fail_count++;
        test_done;
    end

endmodule : pwm_carrier_counter_buffer_update_tb_top

`default_nettype wire
